// ==== design/rsc_pkg.sv ====
/*
 * rsc_pkg: selector codes, field positions, fixed words and reset values
 * for the ramp synthesizer configuration bank.
 * Assumes 32-bit serial words whose low five bits select the register.
 */
package rsc_pkg;
    localparam int WORD_W = 32;
    localparam int SEL_W = 5;

    // register selectors
    localparam logic [4:0] SEL_SYNTH_MAIN = 5'h05;
    localparam logic [4:0] SEL_REF_OPT = 5'h07;
    localparam logic [4:0] SEL_REF_CAL = 5'h08;
    localparam logic [4:0] SEL_CAL_SETUP = 5'h09;
    localparam logic [4:0] SEL_RSV_A = 5'h0A;
    localparam logic [4:0] SEL_RAMP_MODE = 5'h0B;
    localparam logic [4:0] SEL_PUMP = 5'h0C;
    localparam logic [4:0] SEL_TIMER = 5'h0D;
    localparam logic [4:0] SEL_DEV = 5'h0E;
    localparam logic [4:0] SEL_STEP = 5'h0F;
    localparam logic [4:0] SEL_DELAY = 5'h10;
    localparam logic [4:0] SEL_RSV_B = 5'h11;

    // reference options word
    localparam int REF_HALF_BIT = 11;
    localparam int DOUBLER_BIT = 10;
    localparam int REF_DIV_LSB = 5;
    localparam int REF_DIV_W = 5;
    // calibration divider
    localparam int CAL_DIV_LSB = 5;
    localparam int CAL_DIV_W = 10;
    // ramp mode control
    localparam int NSR_HOLD_BIT = 11;
    localparam int SINGLE_TRI_BIT = 9;
    localparam int RAMP_MODE_LSB = 7;
    localparam int RAMP_MODE_W = 2;
    localparam int CNT_CLR_BIT = 5;
    // pump control
    localparam int PUMP_LSB = 17;
    localparam int PUMP_W = 4;
    localparam int PUMP_TRI_BIT = 15;
    // ramp timer divider
    localparam int LSYNC_BIT = 21;
    localparam int DIV_MODE_LSB = 19;
    localparam int DIV_MODE_W = 2;
    localparam int TDIV_LSB = 7;
    localparam int TDIV_W = 12;
    localparam int TSEL_LSB = 5;
    // deviation
    localparam int TRIG_INV_BIT = 31;
    localparam int RCLK_SRC_BIT = 30;
    localparam int DSEL_LSB = 25;
    localparam int DOFF_LSB = 21;
    localparam int DOFF_W = 4;
    localparam int DEV_LSB = 5;
    localparam int DEV_W = 16;
    // step
    localparam int SSEL_LSB = 25;
    localparam int STEP_LSB = 3;
    localparam int STEP_W = 20;
    // delay and trigger
    localparam int DLSEL_LSB = 23;
    localparam int TRIG_EN_BIT = 20;
    localparam int DLY_EN_BIT = 19;
    localparam int DLY_LSB = 5;
    localparam int DLY_W = 12;
    // main synth word
    localparam int RAMP_ON_BIT = 29;

    localparam int SLOT_SEL_W = 2;
    localparam int SLOTS = 4;

    // fixed words
    localparam logic [31:0] CAL_SETUP_WORD = 32'h2A20B929;
    localparam logic [31:0] NORMAL_SETUP_WORD = 32'h2800B929;
    localparam logic [31:0] RSV_A_WORD = 32'h1D32A64A;
    localparam logic [31:0] RSV_B_WORD = 32'h00000011;

    localparam logic [31:0] WORD_RESET = 32'h00000000;
endpackage

// ==== design/rsc_slot_bank.sv ====
/*
 * rsc_slot_bank: four write-selected slots of one field width.
 * Assumes write enable is a one-cycle pulse on the bank clock.
 */
`timescale 1ns/100ps
module rsc_slot_bank #(
    parameter int W = 12
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // write side
    input wire logic wr_in,
    input wire logic [1:0] sel_in,
    input wire logic [W-1:0] data_in,
    // stored slots, slot 0 in the low bits
    output logic [4*W-1:0] slots_out
);
    logic [4*W-1:0] next_slots;

    always_comb begin
        next_slots = slots_out;
        if (wr_in) begin
            next_slots[sel_in*W +: W] = data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            slots_out <= '0;
        end else begin
            slots_out <= next_slots;
        end
    end
endmodule // rsc_slot_bank

// ==== design/rsc_config_regs.sv ====
/*
 * rsc_config_regs: serial-loaded configuration bank for the reference path,
 * calibration divider, ramp control, pump code and ramp slot banks.
 * Assumes serial, strobe, reference and trigger inputs synchronous to mclk_in.
 */
`timescale 1ns/100ps
// Operation
// RULE_01: reference-half bit inserts a divide-by-two stage before calibration tick.
// RULE_02: doubler bit doubles reference edges feeding the reference divider.
// RULE_03: doubler off uses falling edge only; on uses both edges.
// RULE_04: reference divider divides by 1 to 31; host keeps it there.
// RULE_05: low five bits route each word to registers 8 through 17; code also decodes registers 5 and 7.
// RULE_06: host sets calibration divider so detector rate over it <= 100 kHz.
// RULE_07: host writes calibration word before calibration, normal word afterwards.
// RULE_08: host writes registers 10 and 17 only with their fixed words.
// RULE_09: noise-shaper reset on each main word write unless hold bit set.
// RULE_10: single-full-triangle bit enables function; host pairs it with mode 11.
// RULE_11: two-bit ramp mode field selects the generated waveform.
// RULE_12: counter-clear bit holds device counters reset until cleared.
// RULE_13: four-bit pump current code and separate pump tristate bit.
// RULE_14: latch-sync bit delays strobe action until a reference edge.
// RULE_15: host sets divider mode 11 with ramps, 00 otherwise.
// RULE_16: timer divisor stored into slot picked by segment select.
// RULE_17: trigger invert selects rising or falling trigger edge.
// RULE_18: ramp clock source picks timer tick or trigger pin.
// RULE_19: deviation word and offset stored into selected deviation slot.
// RULE_20: step count stored into selected step slot.
// RULE_21: delay word stored into selected slot; separate delay enable bit.
// RULE_22: trigger mode starts ramp on trigger high together with ramp-on.
// RULE_23: ramp-on bit starts ramp when 1, disables it when 0.
// RULE_24: word taken only on load strobe, then only addressed register updated.
module rsc_config_regs (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rstn_in,
    // serial port
    input wire logic sclk_in,
    input wire logic sdata_in,
    input wire logic load_strobe_pin_in,
    // reference and trigger pins
    input wire logic ref_in,
    input wire logic trig_pin_in,
    // reference path
    output logic ref_half_divider_out,
    output logic doubler_out,
    output logic [4:0] ref_div_out,
    output logic [9:0] cal_div_out,
    output logic pd_tick_out,
    output logic cal_tick_out,
    // calibration and fixed words
    output logic cal_mode_out,
    output logic reserved_ok_out,
    // ramp control
    output logic [1:0] ramp_mode_out,
    output logic single_tri_out,
    output logic counter_clear_bit_out,
    output logic noise_shaper_reset_out,
    output logic [1:0] divider_mode_field_out,
    output logic ramp_run_out,
    output logic ramp_adv_out,
    output logic delay_en_out,
    // pump
    output logic [3:0] pump_code_out,
    output logic pump_tristate_out,
    // slot banks, slot 0 in low bits
    output logic [47:0] ramp_timer_divisor_out,
    output logic [63:0] dev_word_out,
    output logic [15:0] dev_offset_out,
    output logic [79:0] step_count_out,
    output logic [47:0] delay_word_out
);
    logic [31:0] shift, next_shift;
    logic [31:0] held, next_held;
    logic pend, next_pend;
    logic sclk_q, le_q, ref_q, trig_q;
    logic commit;
    logic [31:0] cword;
    logic [4:0] csel;
    logic [31:0] ref_opt, r8, r9, r10, r11, r12, r13, r17;
    logic [31:0] next_ref_opt, next_r8, next_r9, next_r10, next_r11, next_r12, next_r13, next_r17;
    logic trig_inv, rclk_src, trig_en, dly_en, ramp_on;
    logic next_trig_inv, next_rclk_src, next_trig_en, next_dly_en, next_ramp_on;
    logic next_nsr_reset;
    logic next_cal_mode, next_rsv_ok;
    logic sclk_rise, le_rise, ref_rise, ref_fall, trig_rise, trig_fall;
    logic [4:0] rcnt, next_rcnt, rdiv;
    logic half, next_half;
    logic pd_edge, rdiv_tick, next_cal_tick;
    logic [11:0] tcnt, next_tcnt, tdiv;
    logic timer_tick, trig_evt, next_adv, next_run;

    assign sclk_rise = sclk_in & ~sclk_q;
    assign le_rise = load_strobe_pin_in & ~le_q;
    assign ref_rise = ref_in & ~ref_q;
    assign ref_fall = ~ref_in & ref_q;
    assign trig_rise = trig_pin_in & ~trig_q;
    assign trig_fall = ~trig_pin_in & trig_q;
    assign csel = cword[4:0];

    // serial capture and strobe handling
    always_comb begin
        next_shift = shift;
        next_held = held;
        next_pend = pend;
        commit = 1'b0;
        cword = held;
        if (sclk_rise) begin
            next_shift = {shift[30:0], sdata_in};
        end
        if (pend && ref_rise) begin
            commit = 1'b1; // see RULE_14
            next_pend = 1'b0;
        end
        if (le_rise) begin
            if (r13[rsc_pkg::LSYNC_BIT]) begin
                next_pend = 1'b1; // see RULE_14
                next_held = shift;
            end else begin
                commit = 1'b1; // see RULE_24
                cword = shift;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            shift <= rsc_pkg::WORD_RESET;
            held <= rsc_pkg::WORD_RESET;
            pend <= 1'b0;
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            ref_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            shift <= next_shift;
            held <= next_held;
            pend <= next_pend;
            sclk_q <= sclk_in;
            le_q <= load_strobe_pin_in;
            ref_q <= ref_in;
            trig_q <= trig_pin_in;
        end
    end

    // register words, routed by selector
    always_comb begin
        next_ref_opt = ref_opt;
        next_r8 = r8;
        next_r9 = r9;
        next_r10 = r10;
        next_r11 = r11;
        next_r12 = r12;
        next_r13 = r13;
        next_r17 = r17;
        next_trig_inv = trig_inv;
        next_rclk_src = rclk_src;
        next_trig_en = trig_en;
        next_dly_en = dly_en;
        next_ramp_on = ramp_on;
        next_nsr_reset = 1'b0;
        if (commit) begin
            case (csel) // see RULE_05
                rsc_pkg::SEL_SYNTH_MAIN: begin
                    next_ramp_on = cword[rsc_pkg::RAMP_ON_BIT]; // see RULE_23
                    next_nsr_reset = ~r11[rsc_pkg::NSR_HOLD_BIT]; // see RULE_09
                end
                rsc_pkg::SEL_REF_OPT: next_ref_opt = cword;
                rsc_pkg::SEL_REF_CAL: next_r8 = cword; // see RULE_06
                rsc_pkg::SEL_CAL_SETUP: next_r9 = cword;
                rsc_pkg::SEL_RSV_A: next_r10 = cword;
                rsc_pkg::SEL_RAMP_MODE: next_r11 = cword;
                rsc_pkg::SEL_PUMP: next_r12 = cword;
                rsc_pkg::SEL_TIMER: next_r13 = cword;
                rsc_pkg::SEL_DEV: begin
                    next_trig_inv = cword[rsc_pkg::TRIG_INV_BIT];
                    next_rclk_src = cword[rsc_pkg::RCLK_SRC_BIT];
                end
                rsc_pkg::SEL_DELAY: begin
                    next_trig_en = cword[rsc_pkg::TRIG_EN_BIT];
                    next_dly_en = cword[rsc_pkg::DLY_EN_BIT]; // see RULE_21
                end
                rsc_pkg::SEL_RSV_B: next_r17 = cword;
                default: next_nsr_reset = 1'b0;
            endcase
        end
        next_cal_mode = (next_r9 == rsc_pkg::CAL_SETUP_WORD); // see RULE_07
        next_rsv_ok = (next_r10 == rsc_pkg::RSV_A_WORD) && (next_r17 == rsc_pkg::RSV_B_WORD); // see RULE_08
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            ref_opt <= rsc_pkg::WORD_RESET;
            r8 <= rsc_pkg::WORD_RESET;
            r9 <= rsc_pkg::WORD_RESET;
            r10 <= rsc_pkg::WORD_RESET;
            r11 <= rsc_pkg::WORD_RESET;
            r12 <= rsc_pkg::WORD_RESET;
            r13 <= rsc_pkg::WORD_RESET;
            r17 <= rsc_pkg::WORD_RESET;
            trig_inv <= 1'b0;
            rclk_src <= 1'b0;
            trig_en <= 1'b0;
            dly_en <= 1'b0;
            ramp_on <= 1'b0;
            noise_shaper_reset_out <= 1'b0;
            cal_mode_out <= 1'b0;
            reserved_ok_out <= 1'b0;
        end else begin
            ref_opt <= next_ref_opt;
            r8 <= next_r8;
            r9 <= next_r9;
            r10 <= next_r10;
            r11 <= next_r11;
            r12 <= next_r12;
            r13 <= next_r13;
            r17 <= next_r17;
            trig_inv <= next_trig_inv;
            rclk_src <= next_rclk_src;
            trig_en <= next_trig_en;
            dly_en <= next_dly_en;
            ramp_on <= next_ramp_on;
            noise_shaper_reset_out <= next_nsr_reset;
            cal_mode_out <= next_cal_mode;
            reserved_ok_out <= next_rsv_ok;
        end
    end

    assign ref_half_divider_out = ref_opt[rsc_pkg::REF_HALF_BIT];
    assign doubler_out = ref_opt[rsc_pkg::DOUBLER_BIT];
    assign ref_div_out = ref_opt[rsc_pkg::REF_DIV_LSB +: rsc_pkg::REF_DIV_W];
    assign cal_div_out = r8[rsc_pkg::CAL_DIV_LSB +: rsc_pkg::CAL_DIV_W];
    assign ramp_mode_out = r11[rsc_pkg::RAMP_MODE_LSB +: rsc_pkg::RAMP_MODE_W]; // see RULE_11
    assign single_tri_out = r11[rsc_pkg::SINGLE_TRI_BIT]; // see RULE_10
    assign counter_clear_bit_out = r11[rsc_pkg::CNT_CLR_BIT];
    assign pump_code_out = r12[rsc_pkg::PUMP_LSB +: rsc_pkg::PUMP_W]; // see RULE_13
    assign pump_tristate_out = r12[rsc_pkg::PUMP_TRI_BIT]; // see RULE_13
    assign divider_mode_field_out = r13[rsc_pkg::DIV_MODE_LSB +: rsc_pkg::DIV_MODE_W]; // see RULE_15
    assign delay_en_out = dly_en;

    // slot banks
    rsc_slot_bank #(.W(rsc_pkg::TDIV_W)) u_timer (
        .mclk_in(mclk_in), .rstn_in(rstn_in),
        .wr_in(commit && csel == rsc_pkg::SEL_TIMER), // see RULE_16
        .sel_in(cword[rsc_pkg::TSEL_LSB +: rsc_pkg::SLOT_SEL_W]),
        .data_in(cword[rsc_pkg::TDIV_LSB +: rsc_pkg::TDIV_W]),
        .slots_out(ramp_timer_divisor_out)
    );
    rsc_slot_bank #(.W(rsc_pkg::DEV_W)) u_dev (
        .mclk_in(mclk_in), .rstn_in(rstn_in),
        .wr_in(commit && csel == rsc_pkg::SEL_DEV), // see RULE_19
        .sel_in(cword[rsc_pkg::DSEL_LSB +: rsc_pkg::SLOT_SEL_W]),
        .data_in(cword[rsc_pkg::DEV_LSB +: rsc_pkg::DEV_W]),
        .slots_out(dev_word_out)
    );
    rsc_slot_bank #(.W(rsc_pkg::DOFF_W)) u_doff (
        .mclk_in(mclk_in), .rstn_in(rstn_in),
        .wr_in(commit && csel == rsc_pkg::SEL_DEV), // see RULE_19
        .sel_in(cword[rsc_pkg::DSEL_LSB +: rsc_pkg::SLOT_SEL_W]),
        .data_in(cword[rsc_pkg::DOFF_LSB +: rsc_pkg::DOFF_W]),
        .slots_out(dev_offset_out)
    );
    rsc_slot_bank #(.W(rsc_pkg::STEP_W)) u_step (
        .mclk_in(mclk_in), .rstn_in(rstn_in),
        .wr_in(commit && csel == rsc_pkg::SEL_STEP), // see RULE_20
        .sel_in(cword[rsc_pkg::SSEL_LSB +: rsc_pkg::SLOT_SEL_W]),
        .data_in(cword[rsc_pkg::STEP_LSB +: rsc_pkg::STEP_W]),
        .slots_out(step_count_out)
    );
    rsc_slot_bank #(.W(rsc_pkg::DLY_W)) u_delay (
        .mclk_in(mclk_in), .rstn_in(rstn_in),
        .wr_in(commit && csel == rsc_pkg::SEL_DELAY), // see RULE_21
        .sel_in(cword[rsc_pkg::DLSEL_LSB +: rsc_pkg::SLOT_SEL_W]),
        .data_in(cword[rsc_pkg::DLY_LSB +: rsc_pkg::DLY_W]),
        .slots_out(delay_word_out)
    );

    // reference path and ramp timing
    always_comb begin
        pd_edge = doubler_out ? (ref_rise | ref_fall) : ref_fall; // see RULE_02 see RULE_03
        rdiv = (ref_div_out == 5'h00) ? 5'h01 : ref_div_out; // see RULE_04
        tdiv = (ramp_timer_divisor_out[11:0] == 12'h000) ? 12'h001 : ramp_timer_divisor_out[11:0];
        rdiv_tick = 1'b0;
        timer_tick = 1'b0;
        next_rcnt = rcnt;
        next_tcnt = tcnt;
        if (pd_edge) begin
            if (rcnt >= rdiv - 5'h01) begin
                next_rcnt = 5'h00;
                rdiv_tick = 1'b1;
            end else begin
                next_rcnt = rcnt + 5'h01;
            end
            if (tcnt >= tdiv - 12'h001) begin
                next_tcnt = 12'h000;
                timer_tick = 1'b1;
            end else begin
                next_tcnt = tcnt + 12'h001;
            end
        end
        if (counter_clear_bit_out) begin
            next_rcnt = 5'h00; // see RULE_12
            next_tcnt = 12'h000;
            rdiv_tick = 1'b0;
            timer_tick = 1'b0;
        end
        next_half = ref_half_divider_out ? (half ^ rdiv_tick) : 1'b0;
        next_cal_tick = ref_half_divider_out ? (rdiv_tick & half) : rdiv_tick; // see RULE_01
        trig_evt = trig_inv ? trig_fall : trig_rise; // see RULE_17
        next_run = ramp_on && (!trig_en || trig_pin_in); // see RULE_22 see RULE_23
        next_adv = next_run && (rclk_src ? trig_evt : timer_tick); // see RULE_18
    end

    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            rcnt <= 5'h00;
            tcnt <= 12'h000;
            half <= 1'b0;
            pd_tick_out <= 1'b0;
            cal_tick_out <= 1'b0;
            ramp_run_out <= 1'b0;
            ramp_adv_out <= 1'b0;
        end else begin
            rcnt <= next_rcnt;
            tcnt <= next_tcnt;
            half <= next_half;
            pd_tick_out <= pd_edge;
            cal_tick_out <= next_cal_tick;
            ramp_run_out <= next_run;
            ramp_adv_out <= next_adv;
        end
    end

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    sequence s_pump_write;
        commit && csel == rsc_pkg::SEL_PUMP;
    endsequence
    sequence s_sync_strobe;
        le_rise && r13[rsc_pkg::LSYNC_BIT] && !pend;
    endsequence

    chk_pump_route: assert property (s_pump_write |=> r12 == $past(cword)) // see RULE_05
        else $error("pump word not stored");
    chk_strobe_wait: assert property (s_sync_strobe |-> !commit ##1 pend) // see RULE_14
        else $error("synced strobe acted early");
    chk_nsr_pulse: assert property (commit && csel == rsc_pkg::SEL_SYNTH_MAIN && !r11[rsc_pkg::NSR_HOLD_BIT]
        |=> noise_shaper_reset_out) // see RULE_09
        else $error("noise shaper reset missing");
    chk_nsr_hold: assert property (noise_shaper_reset_out |-> !$past(r11[rsc_pkg::NSR_HOLD_BIT])) // see RULE_09
        else $error("noise shaper reset while held");
    chk_counter_hold: assert property (counter_clear_bit_out [*2] |-> !ramp_adv_out && !cal_tick_out) // see RULE_12
        else $error("counters ran while cleared");
    chk_fall_only: assert property ($past(ref_rise) && !$past(doubler_out) |-> !pd_tick_out) // see RULE_03
        else $error("rising edge active without doubler");
    chk_src_trigger: assert property (ramp_adv_out && $past(rclk_src) |-> $past(trig_evt)) // see RULE_18
        else $error("ramp advanced without trigger");
    chk_trig_edge: assert property (trig_inv && trig_rise |=> !(ramp_adv_out && $past(rclk_src))) // see RULE_17
        else $error("wrong trigger edge used");
    chk_run_gate: assert property (ramp_run_out |-> $past(ramp_on) && (!$past(trig_en) || $past(trig_pin_in)))
        else $error("ramp ran without start"); // see RULE_22
    chk_half_stage: assert property (ref_half_divider_out && cal_tick_out [*2] |-> 1'b0) // see RULE_01
        else $error("half stage passed consecutive ticks");
endmodule // rsc_config_regs

// ==== dv/rsc_host_model.sv ====
/* rsc_host_model: host side of the serial programming port.
   Assumes the caller enters wr between clock edges; one word at a time. */
`timescale 1ns/100ps
module rsc_host_model (
    // clock
    input wire logic mclk_in,
    // serial port
    output logic sclk_out,
    output logic sdata_out,
    output logic load_strobe_pin_out
);
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        load_strobe_pin_out = 1'b0;
    end
    // msb first, clock stands low outside frames
    task automatic wr(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge mclk_in);
            sdata_out <= w[i];
            sclk_out <= 1'b1;
            @(posedge mclk_in);
            sclk_out <= 1'b0;
        end
        @(posedge mclk_in);
        sdata_out <= ~w[0];
        load_strobe_pin_out <= 1'b1;
        @(posedge mclk_in);
        load_strobe_pin_out <= 1'b0;
        #1;
    endtask
endmodule // rsc_host_model

// ==== dv/rsc_config_regs_bench.sv ====
/* rsc_config_regs_bench: self-checking bench for the configuration bank.
   Assumes rsc_host_model frames the words; reference and trigger driven here. */
`timescale 1ns/100ps
module rsc_config_regs_bench;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ref_in = 1'b0;
    logic trig_pin_in = 1'b0;
    wire sclk, sdata, strobe, r_half, dbl, pd_tick, cal_tick, cal_mode, rsv_ok, s_tri, cclr, ns_rst;
    wire run, adv, dly_en, p_tri;
    wire [4:0] r_div;
    wire [9:0] c_div;
    wire [1:0] r_mode, d_mode;
    wire [3:0] p_code;
    wire [47:0] t_div, dly;
    wire [63:0] dev;
    wire [15:0] d_off;
    wire [79:0] step;
    logic [47:0] e_t = '0, e_l = '0;
    logic [63:0] e_d = '0;
    logic [15:0] e_o = '0;
    logic [79:0] e_s = '0;
    int failures = 0;
    int cmp_count = 0;
    always #5 mclk_in = ~mclk_in;
    rsc_host_model host_u (.mclk_in(mclk_in), .sclk_out(sclk), .sdata_out(sdata), .load_strobe_pin_out(strobe));
    rsc_config_regs dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .sclk_in(sclk), .sdata_in(sdata),
        .load_strobe_pin_in(strobe), .ref_in(ref_in), .trig_pin_in(trig_pin_in), .ref_half_divider_out(r_half),
        .doubler_out(dbl), .ref_div_out(r_div), .cal_div_out(c_div), .pd_tick_out(pd_tick),
        .cal_tick_out(cal_tick), .cal_mode_out(cal_mode), .reserved_ok_out(rsv_ok), .ramp_mode_out(r_mode),
        .single_tri_out(s_tri), .counter_clear_bit_out(cclr), .noise_shaper_reset_out(ns_rst),
        .divider_mode_field_out(d_mode), .ramp_run_out(run), .ramp_adv_out(adv), .delay_en_out(dly_en),
        .pump_code_out(p_code), .pump_tristate_out(p_tri), .ramp_timer_divisor_out(t_div),
        .dev_word_out(dev), .dev_offset_out(d_off), .step_count_out(step), .delay_word_out(dly));
    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // reference period of four cycles, ticks counted after each edge
    task automatic run_ref(input int n, output int pd, output int cal, output int ad);
        pd = 0;
        cal = 0;
        ad = 0;
        for (int c = 0; c < 4 * n + 4; c++) begin
            @(posedge mclk_in);
            ref_in <= (c % 4 < 2) && (c < 4 * n);
            #1;
            pd += (pd_tick === 1'b1);
            cal += (cal_tick === 1'b1);
            ad += (adv === 1'b1);
        end
    endtask
    task automatic trig_set(input logic v, output int n);
        n = 0;
        @(posedge mclk_in);
        trig_pin_in <= v; // held for five clock cycles while advances are counted
        repeat (5) begin
            @(posedge mclk_in);
            #1;
            n += (adv === 1'b1);
        end
    endtask
    task automatic t_ref();
        int pd, cal, ad;
        host_u.wr(32'h0000002B);
        host_u.wr(32'h00000867); // ratio 3
        host_u.wr(32'h00007D08);
        chk("ref half", {1'b1, 1'b0, 5'd3}, {r_half, dbl, r_div});
        chk("cal div", 10'h3E8, c_div);
        chk("clear", 1, cclr);
        run_ref(6, pd, cal, ad);
        chk("held cal", 0, cal);
        host_u.wr(32'h0000000B);
        run_ref(24, pd, cal, ad);
        chk("pd falling", 24, pd);
        chk("cal halved", 4, cal);
        host_u.wr(32'h00000467);
        run_ref(24, pd, cal, ad);
        chk("pd both", 48, pd);
        chk("cal doubled", 16, cal);
        $display("done t_ref");
    endtask
    task automatic t_words();
        host_u.wr(rsc_pkg::CAL_SETUP_WORD);
        chk("cal mode", 1, cal_mode);
        host_u.wr(rsc_pkg::NORMAL_SETUP_WORD);
        chk("normal mode", 0, cal_mode);
        host_u.wr(rsc_pkg::RSV_A_WORD);
        host_u.wr(rsc_pkg::RSV_B_WORD);
        chk("rsv ok", 1, rsv_ok);
        host_u.wr(32'h00000031);
        chk("rsv bad", 0, rsv_ok);
        host_u.wr(rsc_pkg::RSV_B_WORD);
        host_u.wr(32'hFFFFFFF2);
        host_u.wr(32'hFFFFFFE6);
        chk("unmapped", {1'b1, 6'h0}, {rsv_ok, r_mode, p_code});
        $display("done t_words");
    endtask
    task automatic t_ramp();
        for (int m = 0; m < 4; m++) begin
            host_u.wr(32'h0000000B | (m << 7) | ((m == 3) << 9));
            chk("mode", {m[1:0], m == 3}, {r_mode, s_tri});
        end
        host_u.wr(32'h20000005);
        chk("ns reset", 1, ns_rst);
        host_u.wr(32'h0000080B);
        host_u.wr(32'h20000005);
        chk("ns hold", 0, ns_rst);
        chk("run", 1, run);
        host_u.wr(32'h0014800C);
        chk("pump", 5'h15, {p_code, p_tri});
        $display("done t_ramp");
    endtask
    task automatic t_slots();
        logic [31:0] w;
        for (int s = 0; s < 4; s++) begin
            e_t[s*12 +: 12] = 12'h101 + s;
            host_u.wr(32'h0018000D | (e_t[s*12 +: 12] << 7) | (s << 5));
            chk("timer", e_t, t_div);
            e_d[s*16 +: 16] = 16'h8000 + s;
            e_o[s*4 +: 4] = 4'h1 + s;
            w = {5'h0, s[1:0], e_o[s*4 +: 4], e_d[s*16 +: 16], 5'h0E};
            host_u.wr(w);
            chk("dev", {e_o, e_d}, {d_off, dev});
            e_s[s*20 +: 20] = 20'h00401 + (s << 8);
            host_u.wr({5'h0, s[1:0], 2'b00, e_s[s*20 +: 20], 3'b111});
            chk("step", e_s, step);
            e_l[s*12 +: 12] = 12'hA50 + s;
            host_u.wr({7'h0, s[1:0], 4'h1, 2'b00, e_l[s*12 +: 12], 5'h10});
            chk("delay", {1'b1, e_l}, {dly_en, dly});
        end
        chk("div mode", 2'b11, d_mode);
        $display("done t_slots");
    endtask
    task automatic t_trig();
        int r, f;
        host_u.wr(32'h00100010);
        @(posedge mclk_in);
        #1;
        chk("run low", 0, run);
        trig_set(1'b1, r);
        chk("run high", 1, run);
        trig_set(1'b0, r);
        host_u.wr(32'h00000010);
        host_u.wr(32'h4000000E);
        trig_set(1'b1, r);
        trig_set(1'b0, f);
        chk("adv rise", {32'd1, 32'd0}, {r, f});
        host_u.wr(32'hC000000E);
        trig_set(1'b1, r);
        trig_set(1'b0, f);
        chk("adv fall", {32'd0, 32'd1}, {r, f});
        host_u.wr(32'h00000005);
        repeat (2) @(posedge mclk_in);
        #1;
        chk("run off", 0, run);
        $display("done t_trig");
    endtask
    task automatic t_sync();
        int pd, cal, ad;
        host_u.wr(32'h0038010D);
        run_ref(1, pd, cal, ad);
        host_u.wr(32'h0002000C);
        chk("sync wait", 4'hA, p_code);
        run_ref(1, pd, cal, ad);
        chk("sync done", 4'h1, p_code);
        host_u.wr(32'h0018010D);
        run_ref(1, pd, cal, ad);
        host_u.wr(32'h0000000E);
        host_u.wr(32'h0000082B);
        host_u.wr(32'h0000080B);
        host_u.wr(32'h20000005);
        run_ref(8, pd, cal, ad);
        chk("timer adv", 8, ad);
        $display("done t_sync");
    endtask
    initial begin
        repeat (4) @(posedge mclk_in);
        rstn_in <= 1'b1;
        @(posedge mclk_in);
        #1;
        chk("reset", 0, {|t_div, |dev, |d_off, |step, |dly, r_half, dbl, r_div, c_div, cal_mode, rsv_ok,
            r_mode, s_tri, cclr, ns_rst, d_mode, run, adv, dly_en, p_code, p_tri, pd_tick, cal_tick});
        t_ref();
        t_words();
        t_ramp();
        t_slots();
        t_trig();
        t_sync();
        stop_test();
    end
    initial begin
        #500000;
        failures++;
        stop_test();
    end
endmodule // rsc_config_regs_bench
